// [common/awc_pkg.sv]
// Constants, register map and state type of the converter window comparator
package awc_pkg;
  localparam int          DATA_W         = 8;
  localparam int          WORD_W         = 16;
  localparam int          RAW_W          = 10;
  localparam int          JUST_PAD_W     = WORD_W - RAW_W;
  localparam int          SEL_W          = 3;
  localparam int          TIMER_N        = 3;
  localparam int          EDGE_N         = 2;
  // Special function register addresses
  localparam logic [7:0]  ADDR_UPPER_LOW  = 8'hC3;
  localparam logic [7:0]  ADDR_UPPER_HIGH = 8'hC4;
  localparam logic [7:0]  ADDR_LOWER_LOW  = 8'hC5;
  localparam logic [7:0]  ADDR_LOWER_HIGH = 8'hC6;
  localparam logic [7:0]  ADDR_CONTROL    = 8'hE8;
  localparam logic [7:0]  ADDR_RESULT_LOW = 8'hBD;
  localparam logic [7:0]  ADDR_RESULT_HIGH = 8'hBE;
  // Reset values
  localparam logic [7:0]  RST_UPPER      = 8'hFF;
  localparam logic [7:0]  RST_LOWER      = 8'h00;
  localparam logic [7:0]  RST_CONTROL    = 8'h00;
  localparam logic [7:0]  RST_RESULT     = 8'h00;
  localparam logic [7:0]  READ_NONE      = 8'h00;
  // Control register bit positions
  localparam int          BIT_SEL_LSB    = 0;
  localparam int          BIT_DONE       = 3;
  localparam int          BIT_BUSY       = 4;
  localparam int          BIT_WINDOW     = 5;
  localparam int          BIT_LEFT       = 6;
  // Start-source codes
  localparam logic [2:0]  SRC_SOFTWARE   = 3'h0;
  localparam logic [2:0]  SRC_TIMER_A    = 3'h1;
  localparam logic [2:0]  SRC_TIMER_B    = 3'h2;
  localparam logic [2:0]  SRC_TIMER_C    = 3'h3;
  localparam logic [2:0]  SRC_EDGE_A     = 3'h4;
  localparam logic [2:0]  SRC_EDGE_B     = 3'h5;
  localparam logic [1:0]  SRC_RESERVED_HI = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_EVAL = 3'b100
  } awc_state_type;
endpackage

// [rtl/awc_window_cmp.sv]
// Window comparison of a result word against two limits
`timescale 1ns/100ps
`default_nettype none
module awc_window_cmp (
  input  wire logic [awc_pkg::WORD_W-1:0] result_in,
  input  wire logic [awc_pkg::WORD_W-1:0] upper_in,
  input  wire logic [awc_pkg::WORD_W-1:0] lower_in,
  output logic                            match_out
);
  wire logic above_upper;
  wire logic below_lower;
  wire logic inside_mode;
  assign above_upper = result_in > upper_in;
  assign below_lower = result_in < lower_in;
  // Mode follows only from the relative order of the limits
  assign inside_mode = lower_in > upper_in; // RULE6
  assign match_out   = inside_mode ? (above_upper && below_lower) // RULE7
                                   : (above_upper || below_lower); // RULE8
endmodule
`default_nettype wire

// [rtl/awc_top.sv]
// Converter control: start source selection, result capture and window detector
// Operation
// [RULE1] Code 000: writing one to the busy bit starts a conversion.
// [RULE2] Code 011: a conversion starts on that code's timer overflow.
// [RULE3] Codes 100, 101 start on trigger rising edges; 11x reserved, never start.
// [RULE4] Results are compared against programmed limits without processor help.
// [RULE5] A match sets the window flag in the control register, pollable and interruptive.
// [RULE6] Inside or outside reporting depends only on which limit is larger.
// [RULE7] Lower limit above upper: flag when result strictly between them.
// [RULE8] Lower limit not above upper: flag when below lower or above upper.
// [RULE9] Each limit is a sixteen-bit word of high and low byte.
// [RULE10] Upper limit high byte at 0xC4, read-write, resets to all ones.
// [RULE11] Upper limit low byte at 0xC3, read-write.
// [RULE12] Lower limit high byte at 0xC6, read-write, resets to zero.
// [RULE13] Lower limit low byte at 0xC5, read-write, resets to zero.
// [RULE14] Window evaluated on each completion using the current justification.
`timescale 1ns/100ps
`default_nettype none
module awc_top (
  input  wire logic                              clk_in,
  input  wire logic                              reset_in,
  input  wire logic [7:0]                        sfr_addr_in,
  input  wire logic                              sfr_wr_in,
  input  wire logic                              sfr_rd_in,
  input  wire logic [awc_pkg::DATA_W-1:0]        sfr_wdata_in,
  output logic      [awc_pkg::DATA_W-1:0]        sfr_rdata_out,
  input  wire logic [awc_pkg::TIMER_N-1:0]       timer_overflow_in,
  input  wire logic [awc_pkg::EDGE_N-1:0]        trigger_in,
  input  wire logic                              conv_done_in,
  input  wire logic [awc_pkg::RAW_W-1:0]         conv_data_in,
  output logic                                   conv_start_out,
  output logic                                   busy_out,
  output logic                                   window_flag_out
);
  logic [awc_pkg::DATA_W-1:0] upper_high_reg;
  logic [awc_pkg::DATA_W-1:0] upper_low_reg;
  logic [awc_pkg::DATA_W-1:0] lower_high_reg;
  logic [awc_pkg::DATA_W-1:0] lower_low_reg;
  logic [awc_pkg::WORD_W-1:0] result_reg;
  logic [awc_pkg::SEL_W-1:0]  sel_reg;
  logic                       left_reg;
  logic                       busy_reg;
  logic                       done_reg;
  logic                       window_reg;
  logic                       start_reg;
  logic [awc_pkg::EDGE_N-1:0] trigger_prev_reg;
  awc_pkg::awc_state_type     state_reg;
  awc_pkg::awc_state_type     state_next;

  function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  wire logic                       wr_ctrl;
  wire logic [awc_pkg::EDGE_N-1:0] trigger_rise;
  wire logic                       sw_start;
  wire logic                       hw_start;
  wire logic                       start_now;
  wire logic                       match;
  wire logic                       match_set;
  wire logic                       done_set;
  wire logic [awc_pkg::WORD_W-1:0] upper_word;
  wire logic [awc_pkg::WORD_W-1:0] lower_word;
  wire logic [awc_pkg::WORD_W-1:0] justified;
  wire logic [awc_pkg::DATA_W-1:0] ctrl_view;
  wire logic [awc_pkg::DATA_W-1:0] read_mux;

  assign wr_ctrl = wr_hit(sfr_wr_in, sfr_addr_in, awc_pkg::ADDR_CONTROL);

  genvar g;
  generate
    for (g = 0; g < awc_pkg::EDGE_N; g++) begin : g_edge
      assign trigger_rise[g] = trigger_in[g] && !trigger_prev_reg[g]; // RULE3
    end
  endgenerate

  // Software start only in code 000, using the select value being written
  assign sw_start = wr_ctrl && sfr_wdata_in[awc_pkg::BIT_BUSY]
                    && (sfr_wdata_in[awc_pkg::BIT_SEL_LSB +: awc_pkg::SEL_W]
                        == awc_pkg::SRC_SOFTWARE); // RULE1
  assign hw_start =
      ((sel_reg == awc_pkg::SRC_TIMER_A) && timer_overflow_in[0])
   || ((sel_reg == awc_pkg::SRC_TIMER_B) && timer_overflow_in[1])
   || ((sel_reg == awc_pkg::SRC_TIMER_C) && timer_overflow_in[2]) // RULE2
   || ((sel_reg == awc_pkg::SRC_EDGE_A)  && trigger_rise[0])
   || ((sel_reg == awc_pkg::SRC_EDGE_B)  && trigger_rise[1]); // RULE3
  // Starts while a conversion runs are dropped
  assign start_now = (state_reg == awc_pkg::ST_IDLE) && (sw_start || hw_start);

  assign upper_word = {upper_high_reg, upper_low_reg}; // RULE9
  assign lower_word = {lower_high_reg, lower_low_reg}; // RULE9
  assign justified  = left_reg ? {conv_data_in, {awc_pkg::JUST_PAD_W{1'b0}}}
                               : {{awc_pkg::JUST_PAD_W{1'b0}}, conv_data_in}; // RULE14

  awc_window_cmp u_cmp (
    .result_in (result_reg),
    .upper_in  (upper_word),
    .lower_in  (lower_word),
    .match_out (match)
  ); // RULE4

  assign match_set = (state_reg == awc_pkg::ST_EVAL) && match; // RULE14
  assign done_set  = (state_reg == awc_pkg::ST_EVAL);

  always_comb begin
    case (state_reg)
      awc_pkg::ST_IDLE: state_next = start_now ? awc_pkg::ST_BUSY : awc_pkg::ST_IDLE;
      awc_pkg::ST_BUSY: state_next = conv_done_in ? awc_pkg::ST_EVAL : awc_pkg::ST_BUSY;
      awc_pkg::ST_EVAL: state_next = awc_pkg::ST_IDLE;
      default:          state_next = awc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg        <= awc_pkg::ST_IDLE;
      start_reg        <= 1'b0;
      trigger_prev_reg <= '0;
    end else begin
      state_reg        <= state_next;
      start_reg        <= start_now;
      trigger_prev_reg <= trigger_in;
    end
  end

  // Limit registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      upper_high_reg <= awc_pkg::RST_UPPER; // RULE10
      upper_low_reg  <= awc_pkg::RST_UPPER; // RULE11
      lower_high_reg <= awc_pkg::RST_LOWER; // RULE12
      lower_low_reg  <= awc_pkg::RST_LOWER; // RULE13
    end else begin
      if (wr_hit(sfr_wr_in, sfr_addr_in, awc_pkg::ADDR_UPPER_HIGH)) begin
        upper_high_reg <= sfr_wdata_in; // RULE10
      end
      if (wr_hit(sfr_wr_in, sfr_addr_in, awc_pkg::ADDR_UPPER_LOW)) begin
        upper_low_reg <= sfr_wdata_in; // RULE11
      end
      if (wr_hit(sfr_wr_in, sfr_addr_in, awc_pkg::ADDR_LOWER_HIGH)) begin
        lower_high_reg <= sfr_wdata_in; // RULE12
      end
      if (wr_hit(sfr_wr_in, sfr_addr_in, awc_pkg::ADDR_LOWER_LOW)) begin
        lower_low_reg <= sfr_wdata_in; // RULE13
      end
    end
  end

  // Control register and result capture; hardware set wins over software clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sel_reg    <= awc_pkg::RST_CONTROL[awc_pkg::BIT_SEL_LSB +: awc_pkg::SEL_W];
      left_reg   <= awc_pkg::RST_CONTROL[awc_pkg::BIT_LEFT];
      busy_reg   <= awc_pkg::RST_CONTROL[awc_pkg::BIT_BUSY];
      done_reg   <= awc_pkg::RST_CONTROL[awc_pkg::BIT_DONE];
      window_reg <= awc_pkg::RST_CONTROL[awc_pkg::BIT_WINDOW];
      result_reg <= {awc_pkg::RST_RESULT, awc_pkg::RST_RESULT};
    end else begin
      if (wr_ctrl) begin
        sel_reg  <= sfr_wdata_in[awc_pkg::BIT_SEL_LSB +: awc_pkg::SEL_W];
        left_reg <= sfr_wdata_in[awc_pkg::BIT_LEFT];
      end
      busy_reg   <= start_now || (busy_reg && !done_set);
      done_reg   <= done_set || (wr_ctrl ? sfr_wdata_in[awc_pkg::BIT_DONE] : done_reg);
      window_reg <= match_set
                    || (wr_ctrl ? sfr_wdata_in[awc_pkg::BIT_WINDOW] : window_reg); // RULE5
      if ((state_reg == awc_pkg::ST_BUSY) && conv_done_in) begin
        result_reg <= justified; // RULE14
      end
    end
  end

  assign ctrl_view = {1'b0, left_reg, window_reg, busy_reg, done_reg, sel_reg};
  assign read_mux =
      (sfr_addr_in == awc_pkg::ADDR_UPPER_HIGH)  ? upper_high_reg :
      (sfr_addr_in == awc_pkg::ADDR_UPPER_LOW)   ? upper_low_reg  :
      (sfr_addr_in == awc_pkg::ADDR_LOWER_HIGH)  ? lower_high_reg :
      (sfr_addr_in == awc_pkg::ADDR_LOWER_LOW)   ? lower_low_reg  :
      (sfr_addr_in == awc_pkg::ADDR_CONTROL)     ? ctrl_view      :
      (sfr_addr_in == awc_pkg::ADDR_RESULT_HIGH) ?
          result_reg[awc_pkg::WORD_W-1 -: awc_pkg::DATA_W] :
      (sfr_addr_in == awc_pkg::ADDR_RESULT_LOW)  ? result_reg[awc_pkg::DATA_W-1:0] :
                                                   awc_pkg::READ_NONE;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sfr_rdata_out <= awc_pkg::READ_NONE;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= read_mux;
    end
  end

  assign conv_start_out  = start_reg;
  assign busy_out        = busy_reg;
  assign window_flag_out = window_reg; // RULE5

  // Checks
  a_software_start: assert property (@(posedge clk_in) disable iff (reset_in)
    sw_start && state_reg == awc_pkg::ST_IDLE |=> conv_start_out && busy_out) // RULE1
    else $error("software start did not launch a conversion");
  a_timer_start: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_reg == awc_pkg::SRC_TIMER_C && timer_overflow_in[2] && state_reg == awc_pkg::ST_IDLE
    |=> conv_start_out) // RULE2
    else $error("timer overflow did not start a conversion");
  a_edge_start: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_reg == awc_pkg::SRC_EDGE_A && trigger_in[0] && !$past(trigger_in[0])
    && state_reg == awc_pkg::ST_IDLE |=> conv_start_out) // RULE3
    else $error("trigger edge did not start a conversion");
  a_reserved_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_reg[2:1] == awc_pkg::SRC_RESERVED_HI && !wr_ctrl |=> !conv_start_out) // RULE3
    else $error("reserved source started a conversion");
  a_flag_on_match: assert property (@(posedge clk_in) disable iff (reset_in)
    conv_done_in && state_reg == awc_pkg::ST_BUSY ##1 match |=> window_flag_out) // RULE5
    else $error("window match did not set the flag");
  a_inside_mode: assert property (@(posedge clk_in) disable iff (reset_in)
    lower_word > upper_word && match |-> result_reg > upper_word && result_reg < lower_word)
    // RULE7
    else $error("inside window match outside the limits");
  a_outside_mode: assert property (@(posedge clk_in) disable iff (reset_in)
    lower_word <= upper_word && match |-> result_reg < lower_word || result_reg > upper_word)
    // RULE8
    else $error("outside window match inside the limits");
  a_upper_reset: assert property (@(posedge clk_in)
    reset_in |=> upper_high_reg == awc_pkg::RST_UPPER) // RULE10
    else $error("upper high byte reset value wrong");
  a_upper_low_write: assert property (@(posedge clk_in) disable iff (reset_in)
    sfr_wr_in && sfr_addr_in == awc_pkg::ADDR_UPPER_LOW |=> upper_low_reg == $past(sfr_wdata_in))
    // RULE11
    else $error("upper low byte write lost");
  a_lower_reset: assert property (@(posedge clk_in)
    reset_in |=> lower_high_reg == awc_pkg::RST_LOWER && lower_low_reg == awc_pkg::RST_LOWER)
    // RULE12
    else $error("lower limit reset value wrong");
  a_left_justify: assert property (@(posedge clk_in) disable iff (reset_in)
    conv_done_in && state_reg == awc_pkg::ST_BUSY && left_reg
    |=> result_reg[awc_pkg::JUST_PAD_W-1:0] == '0) // RULE14
    else $error("left justified result has low bits set");
  c_inside_match: cover property (@(posedge clk_in) match_set && lower_word > upper_word);
  c_outside_match: cover property (@(posedge clk_in) match_set && lower_word <= upper_word);
  c_timer_start: cover property (@(posedge clk_in) hw_start && start_now);
  c_left_eval: cover property (@(posedge clk_in) done_set && left_reg);
endmodule
`default_nettype wire

// [test/awc_testbench.sv]
// Self-checking testbench for the converter window comparator
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_in;
  logic        reset_in;
  logic [7:0]  sfr_addr_in;
  logic        sfr_wr_in;
  logic        sfr_rd_in;
  logic [7:0]  sfr_wdata_in;
  logic [7:0]  sfr_rdata_out;
  logic [2:0]  timer_overflow_in;
  logic [1:0]  trigger_in;
  logic        conv_done_in;
  logic [9:0]  conv_data_in;
  logic        conv_start_out;
  logic        busy_out;
  logic        window_flag_out;
  int          err_total;
  int          n_checks;
  logic [15:0] up_lim;
  logic [15:0] lo_lim;
  logic        left_j;
  logic [2:0]  src;
  logic [7:0]  rv;
  logic [9:0]  dv [4];
  logic [7:0]  addr_list [4];

  awc_top awc_top_i (.clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .timer_overflow_in(timer_overflow_in),
    .trigger_in(trigger_in), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
    .conv_start_out(conv_start_out), .busy_out(busy_out), .window_flag_out(window_flag_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic tick();
    @(negedge clk_in);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every bus task opens with an edge so strobes never toggle twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    tick();
    sfr_wr_in = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    tick();
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    tick();
    sfr_rd_in = 1'b0;
    tick();
    rv = sfr_rdata_out;
    check(what, {8'h00, e}, {8'h00, rv});
  endtask

  task automatic set_lim(input logic [15:0] up, input logic [15:0] lo);
    wr(awc_pkg::ADDR_UPPER_HIGH, up[15:8]);
    wr(awc_pkg::ADDR_UPPER_LOW, up[7:0]);
    wr(awc_pkg::ADDR_LOWER_HIGH, lo[15:8]);
    wr(awc_pkg::ADDR_LOWER_LOW, lo[7:0]);
    up_lim = up;
    lo_lim = lo;
  endtask

  function automatic logic exp_match(input logic [15:0] r);
    if (lo_lim > up_lim) return (r > up_lim) && (r < lo_lim);
    return (r < lo_lim) || (r > up_lim);
  endfunction

  task automatic watch_start(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      if (conv_start_out === 1'b1) begin
        seen = 1'b1;
        check("busy at start", 16'h0001, {15'h0000, busy_out});
      end
      tick();
    end
    check("start pulse", {15'h0000, exp}, {15'h0000, seen});
    if (exp && !seen) wrap_up();
  endtask

  task automatic pulse(input logic [2:0] b);
    tick();
    timer_overflow_in = b;
    tick();
    timer_overflow_in = 3'h0;
  endtask

  task automatic finish(input logic [9:0] data);
    logic [15:0] r;
    logic        m;
    r = left_j ? {data, 6'h00} : {6'h00, data};
    m = exp_match(r);
    tick();
    conv_data_in = data;
    conv_done_in = 1'b1;
    tick();
    conv_done_in = 1'b0;
    repeat (2) tick();
    check("busy after done", 16'h0000, {15'h0000, busy_out});
    check("window flag", {15'h0000, m}, {15'h0000, window_flag_out});
    rd_chk("result high", awc_pkg::ADDR_RESULT_HIGH, r[15:8]);
    rd_chk("result low", awc_pkg::ADDR_RESULT_LOW, r[7:0]);
    rd_chk("control", awc_pkg::ADDR_CONTROL, {1'b0, left_j, m, 2'b01, src});
    wr(awc_pkg::ADDR_CONTROL, {1'b0, left_j, 3'b000, src});
    tick();
    check("flag cleared", 16'h0000, {15'h0000, window_flag_out});
  endtask

  task automatic run_sw(input logic [9:0] data);
    src = awc_pkg::SRC_SOFTWARE;
    wr(awc_pkg::ADDR_CONTROL, {1'b0, left_j, 6'h10});
    watch_start(1'b1);
    finish(data);
  endtask

  initial begin
    reset_in = 1'b1;
    sfr_addr_in = 8'h00;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    sfr_wdata_in = 8'h00;
    timer_overflow_in = 3'h0;
    trigger_in = 2'h0;
    conv_done_in = 1'b0;
    conv_data_in = 10'h000;
    err_total = 0;
    n_checks = 0;
    left_j = 1'b0;
    src = 3'h0;
    addr_list = '{8'hC3, 8'hC4, 8'hC5, 8'hC6};
    repeat (12) tick();
    reset_in = 1'b0;
    rd_chk("upper high reset", 8'hC4, 8'hFF);
    rd_chk("upper low reset", 8'hC3, 8'hFF);
    rd_chk("lower high reset", 8'hC6, 8'h00);
    rd_chk("lower low reset", 8'hC5, 8'h00);
    rd_chk("control reset", awc_pkg::ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 4; i++) wr(addr_list[i], 8'(8'hA5 + i));
    wr(8'h10, 8'h7E);
    for (int i = 0; i < 4; i++) rd_chk("limit rw", addr_list[i], 8'(8'hA5 + i));
    rd_chk("unmapped", 8'h10, 8'h00);
    set_lim(16'h0040, 16'h0080);
    dv = '{10'h040, 10'h041, 10'h07F, 10'h080};
    for (int i = 0; i < 4; i++) run_sw(dv[i]);
    set_lim(16'h0080, 16'h0040);
    dv = '{10'h03F, 10'h040, 10'h080, 10'h081};
    for (int i = 0; i < 4; i++) run_sw(dv[i]);
    set_lim(16'h0040, 16'h0100);
    left_j = 1'b1;
    dv = '{10'h001, 10'h002, 10'h003, 10'h004};
    for (int i = 0; i < 4; i++) run_sw(dv[i]);
    left_j = 1'b0;
    for (int k = 0; k < 2; k++) begin
      src = 3'(3'h1 + k);
      wr(awc_pkg::ADDR_CONTROL, {5'h00, src});
      pulse(3'h4);
      watch_start(1'b0);
      pulse(3'(3'h1 << k));
      watch_start(1'b1);
      finish(10'h080);
    end
    src = awc_pkg::SRC_TIMER_C;
    wr(awc_pkg::ADDR_CONTROL, {5'h00, src});
    pulse(3'h1);
    watch_start(1'b0);
    pulse(3'h2);
    watch_start(1'b0);
    pulse(3'h4);
    watch_start(1'b1);
    pulse(3'h4);
    watch_start(1'b0);
    finish(10'h010);
    for (int k = 0; k < 2; k++) begin
      src = 3'(4 + k);
      wr(awc_pkg::ADDR_CONTROL, {5'h00, src});
      tick();
      trigger_in[1 - k] = 1'b1;
      watch_start(1'b0);
      trigger_in[k] = 1'b1;
      watch_start(1'b1);
      finish(10'h3FF);
      tick();
      trigger_in = 2'h0;
    end
    for (int k = 6; k < 8; k++) begin
      src = 3'(k);
      wr(awc_pkg::ADDR_CONTROL, {5'h00, src});
      pulse(3'h7);
      watch_start(1'b0);
      trigger_in = 2'h3;
      watch_start(1'b0);
      trigger_in = 2'h0;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
